// ==== src/epiu_pkg.sv ====
package epiu_pkg;
	// Number of maskable external lines
	localparam int NUM_LINES = 8;
	// Sync stages ahead of detection
	localparam int SYNC_STAGES = 2;
	// Majority window of the filter
	localparam int FILTER_TAPS = 3;
	// Reset values of the per-line control bits
	localparam logic RST_ENABLE = 1'b0;
	localparam logic RST_MASK = 1'b0;
	localparam logic RST_MODE = 1'b0;
	localparam logic RST_POL = 1'b0;
	localparam logic RST_FILTER = 1'b0;
	localparam logic RST_ASYNC = 1'b0;
	localparam logic RST_PENDING = 1'b0;
	// Mode bit meanings
	localparam logic MODE_EDGE = 1'b0;
	localparam logic MODE_LEVEL = 1'b1;
endpackage

// ==== src/epiu_ext_pin_irq_unit.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// R1: Each line has its own request output, gated by its own mask bit.
// R2: Each line can trigger on rising edge, falling edge, high level or low level.
// R3: Each line has a selectable spike filter ahead of the pending flag.
// R4: A line set asynchronous detects its level combinationally and wakes the part.
// R5: The non-maskable line has the same options and drives the CPU's NMI request.
// R6: Wake is raised for any enabled trigger, even when the line is masked.
// R7: Mode zero selects edge, one level; polarity zero selects falling/low, one rising/high.
// R8: In synchronous mode the pin passes two sampling flops before the request.
// R9: With the filter on, the trigger counts only if true in two of the last three cycles.
// R10: A pending flag stays set until a one is written to its clear bit or the line is disabled.
// R11: Synchronous edges compare two consecutive synchronised samples in the set direction.
module epiu_ext_pin_irq_unit #(
	parameter int NUM_LINES = epiu_pkg::NUM_LINES
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic sys_rst_in,
	// Pins; index NUM_LINES is the non-maskable line
	input wire logic [NUM_LINES:0] ext_irq_pin_in,
	// Per-line configuration levels
	input wire logic [NUM_LINES:0] mode_in,
	input wire logic [NUM_LINES:0] polarity_in,
	input wire logic [NUM_LINES:0] filter_in,
	input wire logic [NUM_LINES:0] async_in,
	// Enable, disable, mask and clear strobes
	input wire logic [NUM_LINES:0] enable_set_in,
	input wire logic [NUM_LINES:0] enable_clr_in,
	input wire logic [NUM_LINES:0] mask_set_in,
	input wire logic [NUM_LINES:0] mask_clr_in,
	input wire logic [NUM_LINES:0] pending_clr_in,
	// Status
	output logic [NUM_LINES:0] enabled_out,
	output logic [NUM_LINES:0] mask_out,
	output logic [NUM_LINES:0] pending_flags_out,
	// Requests
	output logic [NUM_LINES-1:0] irq_req_out,
	output logic nmi_req_out,
	output logic wake_out
);
	localparam int N = NUM_LINES + 1;
	logic [N-1:0] enable_reg;
	logic [N-1:0] mask_reg;
	logic [N-1:0] pending_reg;
	logic [N-1:0] sync0_reg;
	logic [N-1:0] sync1_reg;
	logic [N-1:0] prev_reg;
	logic [N-1:0] hist1_reg;
	logic [N-1:0] hist2_reg;
	logic [N-1:0] trig_sync;
	logic [N-1:0] trig_cond;
	logic [N-1:0] trig_async;
	logic [N-1:0] hit;
	logic [N-1:0] wake_src;

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_line
			wire logic level_hit;
			wire logic edge_hit;
			wire logic vote;
			// Level against polarity on the second synchronised sample [R7]
			assign level_hit = (sync1_reg[i] == polarity_in[i]); // [R2]
			// Consecutive samples differing toward the polarity [R11]
			assign edge_hit = (sync1_reg[i] != prev_reg[i]) && (sync1_reg[i] == polarity_in[i]);
			assign trig_cond[i] = (mode_in[i] == epiu_pkg::MODE_LEVEL) ? level_hit : edge_hit;
			// Two of three votes [R9]
			assign vote = (trig_cond[i] & hist1_reg[i]) | (trig_cond[i] & hist2_reg[i])
				| (hist1_reg[i] & hist2_reg[i]);
			assign trig_sync[i] = filter_in[i] ? vote : trig_cond[i]; // [R3]
			// Async path reads the raw pin, edges act as levels, no filter [R4]
			assign trig_async[i] = (ext_irq_pin_in[i] == polarity_in[i]);
			assign hit[i] = enable_reg[i] & (async_in[i] ? trig_async[i] : trig_sync[i]);
			// Wake straight from the pin when async, so a stopped clock is no obstacle
			assign wake_src[i] = enable_reg[i] & (async_in[i] ? trig_async[i] : pending_reg[i]);
		end
	endgenerate

	// Synchronous sampling chain [R8]
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			sync0_reg <= '0;
			sync1_reg <= '0;
			prev_reg <= '0;
			hist1_reg <= '0;
			hist2_reg <= '0;
		end else begin
			sync0_reg <= ext_irq_pin_in;
			sync1_reg <= sync0_reg;
			prev_reg <= sync1_reg;
			hist1_reg <= trig_cond;
			hist2_reg <= hist1_reg;
		end
	end

	// Set wins over a write-one clear; disabling always clears [R10]
	always_ff @(posedge clock_in) begin
		if (sys_rst_in) begin
			enable_reg <= {N{epiu_pkg::RST_ENABLE}};
			mask_reg <= {N{epiu_pkg::RST_MASK}};
			pending_reg <= {N{epiu_pkg::RST_PENDING}};
		end else begin
			enable_reg <= (enable_reg | enable_set_in) & ~enable_clr_in;
			mask_reg <= (mask_reg | mask_set_in) & ~mask_clr_in;
			pending_reg <= ((pending_reg & ~pending_clr_in) | hit) & enable_reg
				& ~enable_clr_in; // [R10]
		end
	end

	assign enabled_out = enable_reg;
	assign mask_out = mask_reg;
	assign pending_flags_out = pending_reg;
	// Separate, individually masked requests [R1]
	assign irq_req_out = pending_reg[NUM_LINES-1:0] & mask_reg[NUM_LINES-1:0];
	// Non-maskable line goes to the CPU, still gated by its enable and mask bits [R5]
	assign nmi_req_out = pending_reg[NUM_LINES] & mask_reg[NUM_LINES];
	// Wake regardless of mask [R6]
	assign wake_out = |wake_src;

	// Pin seen at one edge sets the pending flag two edges later
	a_sync_latency: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		(!async_in[0] && !filter_in[0] && mode_in[0] && polarity_in[0] && enable_reg[0]
		&& ext_irq_pin_in[0]) ##2 (!async_in[0] && !filter_in[0] && mode_in[0]
		&& polarity_in[0] && enable_reg[0] && !enable_clr_in[0])
		|=> pending_reg[0]) // [R8]
		else $error("Level request not pending two cycles after pin");
	a_mask_gates: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		irq_req_out[0] |-> (mask_reg[0] && pending_reg[0])) // [R1]
		else $error("Request raised on masked line");
	a_pending_holds: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		(pending_reg[1] && !pending_clr_in[1] && !enable_clr_in[1]) |=> pending_reg[1]) // [R10]
		else $error("Pending flag dropped without clear");
	a_disable_clears: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		enable_clr_in[2] |=> !pending_reg[2] && !enable_reg[2]) // [R10]
		else $error("Disable did not clear pending flag");
	a_filter_vote: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		(filter_in[0] && !async_in[0] && enable_reg[0] && !trig_cond[0] && !hist1_reg[0])
		|-> !hit[0]) // [R9]
		else $error("Filter passed a single-cycle trigger");
	a_edge_once: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		(mode_in[3] == epiu_pkg::MODE_EDGE && $stable(sync1_reg[3]) && $past(sync1_reg[3])
		== prev_reg[3]) |-> !trig_cond[3]) // [R11]
		else $error("Edge trigger without a change");
	a_async_wake: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		(async_in[4] && enable_reg[4] && ext_irq_pin_in[4] == polarity_in[4]) |-> wake_out
		##1 (pending_reg[4] || enable_clr_in[4] || $past(enable_clr_in[4]))) // [R4]
		else $error("Async trigger did not wake");
	a_nmi_route: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		nmi_req_out |-> pending_reg[NUM_LINES] && enabled_out[NUM_LINES]) // [R5]
		else $error("NMI request without pending NMI");
	a_wake_unmasked: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		(pending_reg[5] && enable_reg[5]) |-> wake_out) // [R6]
		else $error("Pending line gave no wake");
	a_level_pol: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		(mode_in[6] && !polarity_in[6] && sync1_reg[6]) |-> !trig_cond[6]) // [R7]
		else $error("Low-level trigger on high pin");

	// Second stage always follows the first by one edge
	a_sync_chain: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		sync1_reg == $past(sync0_reg)) // [R8]
		else $error("Sampling chain skipped a stage");

	// A disabled line never holds a pending flag
	a_disabled_idle: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		(pending_reg & ~enable_reg) == '0) // [R10]
		else $error("Pending flag on a disabled line");

	// Clear with no trigger in the same cycle drops the flag
	a_clear_takes: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		(pending_clr_in[0] && !hit[0]) |=> !pending_reg[0]) // [R10]
		else $error("Clear strobe left flag set");

	// Trigger beats a clear landing in the same cycle
	a_set_wins: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		(hit[0] && !enable_clr_in[0]) |=> pending_reg[0]) // [R10]
		else $error("Trigger lost against clear");

	// Disable beats enable when both strobe together
	a_en_clr_wins: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		(enable_set_in[1] && enable_clr_in[1]) |=> !enable_reg[1]) // [R10]
		else $error("Enable won over disable");

	// Mask clear beats mask set when both strobe together
	a_mask_clr_wins: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		(mask_set_in[1] && mask_clr_in[1]) |=> !mask_reg[1]) // [R1]
		else $error("Mask set won over mask clear");

	// Non-maskable request only from its own flag
	a_nmi_apart: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		!pending_reg[NUM_LINES] |-> !nmi_req_out) // [R5]
		else $error("NMI request without its flag");

	// Async trigger reaches the flag at the next edge
	a_async_flag: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		(async_in[4] && enable_reg[4] && !enable_clr_in[4]
		&& ext_irq_pin_in[4] == polarity_in[4]) |=> pending_reg[4]) // [R4]
		else $error("Async trigger did not set flag");

	// Rising edge seen in edge mode with high polarity
	a_rise_edge: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		(mode_in[7] == epiu_pkg::MODE_EDGE && polarity_in[7] && !prev_reg[7]
		&& sync1_reg[7]) |-> trig_cond[7]) // [R2]
		else $error("Rising edge missed");

	// Falling edge seen in edge mode with low polarity
	a_fall_edge: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		(mode_in[7] == epiu_pkg::MODE_EDGE && !polarity_in[7] && prev_reg[7]
		&& !sync1_reg[7]) |-> trig_cond[7]) // [R7]
		else $error("Falling edge missed");

	// Two agreeing votes must pass the filter
	a_filter_pass: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		(filter_in[3] && !async_in[3] && enable_reg[3] && trig_cond[3] && hist1_reg[3])
		|-> hit[3]) // [R9]
		else $error("Filter blocked a majority trigger");

	// No wake without an enabled pending or async source
	a_wake_quiet: assert property (@(posedge clock_in) disable iff (sys_rst_in)
		((enable_reg & (pending_reg | async_in)) == '0) |-> !wake_out) // [R6]
		else $error("Wake raised with no source");
endmodule

// ==== verification/epiu_pin_model.sv ====
`timescale 1ns/1ps
module epiu_pin_model (
	input wire logic clock_in,
	input wire logic [epiu_pkg::NUM_LINES:0] level_in,
	output logic [epiu_pkg::NUM_LINES:0] ext_irq_pin_out
);
	// Pins move on an edge through a nonblocking update, so the flops still sample the old level
	initial ext_irq_pin_out = 9'h004;
	always @(posedge clock_in) begin
		ext_irq_pin_out <= level_in;
	end
endmodule

// ==== verification/external_pin_interrupt_unit_tb_top.sv ====
`timescale 1ns/1ps
module external_pin_interrupt_unit_tb_top;
	logic clock_in = 0, sys_rst_in = 1, nmi_req_out, wake_out;
	logic [8:0] cmd = 9'h004, pins, mode = 9'h1fb, pol = 9'h1fb, flt = 9'h008, asy = 9'h010;
	logic [8:0] es = 0, ec = 0, ms = 0, mc = 0, pc = 0, en, mk, pend;
	logic [7:0] irq;
	int err_count = 0, samples_checked = 0;
	initial forever #2.5 clock_in = ~clock_in;
	epiu_pin_model pin_u (.clock_in(clock_in), .level_in(cmd), .ext_irq_pin_out(pins));
	epiu_ext_pin_irq_unit dut_u (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
		.ext_irq_pin_in(pins), .mode_in(mode), .polarity_in(pol), .filter_in(flt),
		.async_in(asy), .enable_set_in(es), .enable_clr_in(ec), .mask_set_in(ms),
		.mask_clr_in(mc), .pending_clr_in(pc), .enabled_out(en), .mask_out(mk),
		.pending_flags_out(pend), .irq_req_out(irq), .nmi_req_out(nmi_req_out),
		.wake_out(wake_out));
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask
	task automatic strobe(input logic [8:0] a, b, c, d, e);
		@(posedge clock_in);
		{es, ec, ms, mc, pc} <= {a, b, c, d, e};
		@(posedge clock_in);
		{es, ec, ms, mc, pc} <= '0;
		#1;
	endtask
	task automatic set_pins(input logic [8:0] v);
		@(posedge clock_in);
		cmd <= v;
	endtask
	task automatic t_level;
		strobe(9'h1ff, 0, 9'h1fd, 0, 0);
		check(en, 9'h1ff);
		check(mk, 9'h1fd);
		set_pins(9'h007);
		step(3);
		check(pend, 9'h000);
		step(1);
		check(pend, 9'h003);
		check({1'b0, irq}, 9'h001);
		check(wake_out, 1'b1);
		set_pins(9'h004);
		step(3);
		strobe(0, 0, 0, 0, 9'h003);
		check(pend, 9'h000);
		$display("level test done");
	endtask
	task automatic t_edge;
		set_pins(9'h000);
		step(4);
		check(pend, 9'h004);
		set_pins(9'h004);
		strobe(0, 0, 0, 0, 9'h004);
		step(4);
		check(pend, 9'h000);
		$display("edge test done");
	endtask
	task automatic t_filter;
		set_pins(9'h00c);
		set_pins(9'h004);
		step(5);
		check(pend, 9'h000);
		set_pins(9'h00c);
		step(6);
		check(pend, 9'h008);
		set_pins(9'h004);
		step(4);
		strobe(0, 0, 0, 0, 9'h008);
		check(pend, 9'h000);
		$display("filter test done");
	endtask
	task automatic t_async;
		set_pins(9'h014);
		step(1);
		check(wake_out, 1'b1);
		check(pend, 9'h000);
		step(1);
		check(pend, 9'h010);
		set_pins(9'h004);
		strobe(0, 0, 0, 0, 9'h010);
		$display("async test done");
	endtask
	task automatic t_nmi;
		set_pins(9'h104);
		step(4);
		check(nmi_req_out, 1'b1);
		check(irq[0], 1'b0);
		strobe(0, 9'h100, 0, 0, 0);
		step(3);
		check(pend, 9'h000);
		check(nmi_req_out, 1'b0);
		set_pins(9'h004);
		$display("nmi test done");
	endtask
	task automatic summarize;
		$display("checked %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clock_in);
		sys_rst_in <= 0;
		t_level();
		t_edge();
		t_filter();
		t_async();
		t_nmi();
		summarize();
	end
	initial begin
		#20000;
		err_count++;
		summarize();
	end
endmodule
